// [hdl/com_loader.sv]
// The register addresses and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/1ns
// What this block does
// - Fast RC option: run from internal RC, free both oscillator pins as port 2.
// - RC with RTC option: high clock from RC, 32768Hz crystal also runs.
// - Crystal option: high clock from the external crystal, not the RC.
// - Always-on option: watchdog clock comes only from low-speed RC.
// - Always-on option: low-speed RC never stops in sleep or green.
// - Always-on option: watchdog keeps counting in sleep, green and normal.
// - By-mode option: low-speed RC follows the software operating mode.
// - Watchdog runs only when its option is enabled.
// - Security option enables ROM protection, else it stays off.
// - Configured instruction rate applies on high clock; slow mode uses low/4.
// - Low-power option reduces current in every mode except slow.
// - Addresses 000h-07Fh decode to 128 bytes of general RAM.
// - Addresses 080h-0FFh, except pointer 0E7h, decode to the system register space.
// - Display RAM is 12 bytes at F00h-F0Bh.
// - Indirect pointer reaches RAM at index pair.
module com_loader
	import com_pkg::*;
(
	// Clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// Factory option straps
	input  wire logic [5:0]  opt_strap,
	// AXI4-Lite slave
	input  wire logic [7:0]  s_awaddr,
	input  wire logic        s_awvalid,
	output logic             s_awready,
	input  wire logic [31:0] s_wdata,
	input  wire logic [3:0]  s_wstrb,
	input  wire logic        s_wvalid,
	output logic             s_wready,
	output logic [1:0]       s_bresp,
	output logic             s_bvalid,
	input  wire logic        s_bready,
	input  wire logic [7:0]  s_araddr,
	input  wire logic        s_arvalid,
	output logic             s_arready,
	output logic [31:0]      s_rdata,
	output logic [1:0]       s_rresp,
	output logic             s_rvalid,
	input  wire logic        s_rready,
	// Clock and power controls
	output com_ctrl_t        ctrl
);

	com_opts_t         opts_r;
	logic              opts_done_r;
	logic [1:0]        mode_r;
	logic [7:0]        idx_hi_r;
	logic [7:0]        idx_lo_r;
	logic [11:0]       maddr_r;
	logic [7:0]        gp_mem [GP_WORDS];
	logic [7:0]        disp_mem [DISP_WORDS];
	logic [7:0]        sys_mem [GP_WORDS];
	logic              aw_got_r;
	logic              w_got_r;
	logic [7:0]        awaddr_r;
	logic [31:0]       wdata_r;
	logic [3:0]        wstrb_r;
	logic [11:0]       eff_addr;
	com_region_t       rgn;
	com_ctrl_t         ctrl_nxt;
	logic              wr_go;
	logic              wr_ok;
	logic [5:0]        strap_s1_r;
	logic [5:0]        strap_s2_r;
	logic [5:0]        strap_s3_r;

	// Region decode of a 12-bit data address
	function automatic com_region_t decode(input logic [11:0] a);
		if (a == IND_PTR)
			return RGN_IND;
		if (a <= GP_RAM_HI)
			return RGN_GP;
		if (a >= SYS_REG_LO && a <= SYS_REG_HI)
			return RGN_SYS;
		if (a >= DISP_LO && a <= DISP_HI)
			return RGN_DISP;
		return RGN_NONE;
	endfunction

	// Byte read at a decoded address
	function automatic logic [7:0] mem_rd(input logic [11:0] a);
		unique case (decode(a))
			RGN_GP:   return gp_mem[a[6:0]];
			RGN_SYS:  return sys_mem[a[6:0]];
			RGN_DISP: return disp_mem[a[3:0]];
			default:  return 8'h00;
		endcase
	endfunction

	// Indirect pointer resolves to the index pair
	always_comb begin
		eff_addr = maddr_r;
		if (decode(maddr_r) == RGN_IND)
			eff_addr = {idx_hi_r[3:0], idx_lo_r};
		rgn = decode(eff_addr);
	end

	// Three-stage strap synchroniser, free running so it settles in reset
	always_ff @(posedge aclk) begin
		strap_s1_r <= opt_strap;
		strap_s2_r <= strap_s1_r;
		strap_s3_r <= strap_s2_r;
	end

	// Option capture once after each reset release, on settled straps
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			opts_r      <= '0;
			opts_done_r <= 1'b0;
		end else if (!opts_done_r && strap_s2_r == strap_s3_r) begin
			opts_r      <= com_opts_t'(strap_s3_r);
			opts_done_r <= 1'b1;
		end
	end

	// Clock, watchdog and power control derivation
	always_comb begin
		ctrl_nxt = '0;
		ctrl_nxt.fast_rc_on = (opts_r.hclk_sel != HCLK_CRYSTAL);
		ctrl_nxt.port_two_pins_free =
			(opts_r.hclk_sel == HCLK_FAST_RC);
		ctrl_nxt.rtc_crystal_on = (opts_r.hclk_sel == HCLK_RC_RTC);
		ctrl_nxt.crystal_hi_on = (opts_r.hclk_sel == HCLK_CRYSTAL);
		if (opts_r.low_rc_always_on) begin
			ctrl_nxt.low_rc_on      = 1'b1;
			ctrl_nxt.wdt_clk_low_rc = 1'b1;
			ctrl_nxt.wdt_run        = opts_r.wdt_en;
		end else begin
			ctrl_nxt.low_rc_on  = (mode_r != MODE_SLEEP);
			ctrl_nxt.wdt_clk_low_rc = (mode_r == MODE_SLOW);
			ctrl_nxt.wdt_run    = opts_r.wdt_en &&
				(mode_r != MODE_SLEEP) && (mode_r != MODE_GREEN);
		end
		ctrl_nxt.rom_protect = opts_r.secure_en;
		ctrl_nxt.fcpu_from_slow = (mode_r == MODE_SLOW);
		ctrl_nxt.low_power_act = opts_r.low_power_en &&
			(mode_r != MODE_SLOW);
		if (!opts_done_r)
			ctrl_nxt = '0;
	end

	// Registered control outputs
	always_ff @(posedge aclk) begin
		if (!aresetn)
			ctrl <= '0;
		else
			ctrl <= ctrl_nxt;
	end

	// Write address and data capture, either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_r <= 1'b0;
			w_got_r  <= 1'b0;
			awaddr_r <= 8'h00;
			wdata_r  <= 32'h0000_0000;
			wstrb_r  <= 4'h0;
		end else begin
			if (s_awvalid && s_awready) begin
				aw_got_r <= 1'b1;
				awaddr_r <= s_awaddr;
			end
			if (s_wvalid && s_wready) begin
				w_got_r <= 1'b1;
				wdata_r <= s_wdata;
				wstrb_r <= s_wstrb;
			end
			if (wr_go) begin
				aw_got_r <= 1'b0;
				w_got_r  <= 1'b0;
			end
		end
	end

	assign wr_go = aw_got_r && w_got_r && !s_bvalid;
	assign wr_ok = (awaddr_r == REG_MODE) || (awaddr_r == REG_MADDR) ||
		(awaddr_r == REG_MDATA) || (awaddr_r == REG_INDEX);

	// Ready flags for address and data channels
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_awready <= 1'b0;
			s_wready  <= 1'b0;
		end else begin
			s_awready <= !aw_got_r && !s_awready && !s_bvalid;
			s_wready  <= !w_got_r && !s_wready && !s_bvalid;
			if (s_awvalid && s_awready)
				s_awready <= 1'b0;
			if (s_wvalid && s_wready)
				s_wready <= 1'b0;
		end
	end

	// Write response
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_bvalid <= 1'b0;
			s_bresp  <= RESP_OKAY;
		end else if (wr_go) begin
			s_bvalid <= 1'b1;
			s_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
		end else if (s_bready) begin
			s_bvalid <= 1'b0;
		end
	end

	// Software registers: mode, memory address, index pair
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mode_r   <= MODE_NORMAL;
			maddr_r  <= 12'h000;
			idx_hi_r <= 8'h00;
			idx_lo_r <= 8'h00;
		end else if (wr_go && wstrb_r[0]) begin
			unique case (awaddr_r)
				REG_MODE:  mode_r <= wdata_r[1:0];
				REG_MADDR: maddr_r <= {wstrb_r[1] ? wdata_r[11:8]
					: maddr_r[11:8], wdata_r[7:0]};
				REG_INDEX: begin
					idx_lo_r <= wdata_r[7:0];
					if (wstrb_r[1])
						idx_hi_r <= wdata_r[15:8];
				end
				default: ;
			endcase
		end
	end

	// Data memory write through decoded address
	always_ff @(posedge aclk) begin
		if (wr_go && wstrb_r[0] && awaddr_r == REG_MDATA) begin
			unique case (rgn)
				RGN_GP:   gp_mem[eff_addr[6:0]] <= wdata_r[7:0];
				RGN_SYS:  sys_mem[eff_addr[6:0]] <= wdata_r[7:0];
				RGN_DISP: disp_mem[eff_addr[3:0]] <= wdata_r[7:0];
				default: ;
			endcase
		end
	end

	// Read channel
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_arready <= 1'b0;
			s_rvalid  <= 1'b0;
			s_rdata   <= 32'h0000_0000;
			s_rresp   <= RESP_OKAY;
		end else begin
			s_arready <= !s_rvalid && !s_arready;
			if (s_arvalid && s_arready) begin
				s_arready <= 1'b0;
				s_rvalid  <= 1'b1;
				s_rresp   <= RESP_OKAY;
				unique case (s_araddr)
					REG_OPT:    s_rdata <= {26'h0, opts_r};
					REG_MODE:   s_rdata <= {30'h0, mode_r};
					REG_STAT:   s_rdata <= {22'h0, ctrl_nxt};
					REG_MADDR:  s_rdata <= {20'h0, maddr_r};
					REG_MDATA:  s_rdata <= {24'h0, mem_rd(eff_addr)};
					REG_INDEX:  s_rdata <= {16'h0, idx_hi_r, idx_lo_r};
					REG_DECODE: s_rdata <= {16'h0, eff_addr, rgn};
					default: begin
						s_rdata <= 32'h0000_0000;
						s_rresp <= RESP_SLVERR;
					end
				endcase
			end else if (s_rvalid && s_rready) begin
				s_rvalid <= 1'b0;
			end
		end
	end

	// Checks
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	opts_stable_a: assert property (opts_done_r |=> $stable(opts_r))
		else $error("options changed after capture");
	pins_free_a: assert property (ctrl.port_two_pins_free |->
		ctrl.fast_rc_on && !ctrl.crystal_hi_on)
		else $error("port pins freed without fast rc");
	rtc_osc_a: assert property (ctrl.rtc_crystal_on |->
		ctrl.fast_rc_on && !ctrl.port_two_pins_free)
		else $error("rtc crystal without rc high clock");
	crystal_sel_a: assert property (opts_done_r && opts_r.hclk_sel ==
		HCLK_CRYSTAL |=> ctrl.crystal_hi_on && !ctrl.fast_rc_on)
		else $error("crystal option not honoured");
	always_on_a: assert property (opts_done_r &&
		opts_r.low_rc_always_on |=> ctrl.low_rc_on && ctrl.wdt_clk_low_rc)
		else $error("always-on low rc not kept");
	wdt_keep_a: assert property (opts_done_r &&
		opts_r.low_rc_always_on && opts_r.wdt_en &&
		mode_r == MODE_SLEEP |=> ctrl.wdt_run)
		else $error("watchdog stopped in sleep");
	wdt_gate_a: assert property (!opts_r.wdt_en |=> !ctrl.wdt_run)
		else $error("watchdog running while disabled");
	by_mode_a: assert property (opts_done_r &&
		!opts_r.low_rc_always_on && mode_r == MODE_SLEEP |=>
		!ctrl.low_rc_on)
		else $error("low rc not stopped by mode");
	protect_a: assert property (opts_done_r |=>
		ctrl.rom_protect == $past(opts_r.secure_en))
		else $error("rom protection mismatch");
	slow_lp_a: assert property (mode_r == MODE_SLOW |=>
		!ctrl.low_power_act && ctrl.fcpu_from_slow)
		else $error("slow mode power or clock wrong");
	low_pwr_a: assert property (opts_done_r &&
		opts_r.low_power_en && mode_r == MODE_NORMAL |=>
		ctrl.low_power_act)
		else $error("low power not applied");
	map_gp_a: assert property (maddr_r <= GP_RAM_HI |-> rgn == RGN_GP)
		else $error("general ram decode wrong");
	map_sys_a: assert property (maddr_r >= SYS_REG_LO &&
		maddr_r <= SYS_REG_HI && maddr_r != IND_PTR |-> rgn == RGN_SYS)
		else $error("system area decode wrong");
	map_disp_a: assert property (maddr_r > DISP_HI |-> rgn == RGN_NONE)
		else $error("display range too wide");
	ind_ptr_a: assert property (maddr_r == IND_PTR |->
		eff_addr == {idx_hi_r[3:0], idx_lo_r})
		else $error("indirect pointer address wrong");

	// Option selection and capture
	fast_rc_sel_a: assert property (opts_done_r &&
		opts_r.hclk_sel == HCLK_FAST_RC |=>
		ctrl.fast_rc_on && ctrl.port_two_pins_free)
		else $error("fast rc option not honoured");
	rtc_sel_a: assert property (opts_done_r &&
		opts_r.hclk_sel == HCLK_RC_RTC |=>
		ctrl.fast_rc_on && ctrl.rtc_crystal_on && !ctrl.crystal_hi_on)
		else $error("rc with rtc crystal option not honoured");
	low_rc_green_a: assert property (opts_done_r &&
		opts_r.low_rc_always_on && mode_r == MODE_GREEN |=>
		ctrl.low_rc_on)
		else $error("always-on low rc stopped in green");
	wdt_green_a: assert property (opts_done_r &&
		opts_r.low_rc_always_on && opts_r.wdt_en &&
		mode_r == MODE_GREEN |=> ctrl.wdt_run)
		else $error("watchdog stopped in green");
	fcpu_high_a: assert property (mode_r != MODE_SLOW |=>
		!ctrl.fcpu_from_slow)
		else $error("slow instruction clock outside slow mode");
	opts_capture_a: assert property ($rose(opts_done_r) |->
		opts_r == com_opts_t'($past(strap_s3_r)))
		else $error("options not taken from settled straps");

	// Main scenarios
	wr_resp_c: cover property (wr_go ##1 s_bvalid && s_bready);
	rd_resp_c: cover property (s_rvalid && s_rready);
	ind_use_c: cover property (maddr_r == IND_PTR && rgn == RGN_DISP);
	slow_mode_c: cover property (ctrl.fcpu_from_slow);
	strap_latch_c: cover property ($rose(opts_done_r));

endmodule

// [inc/com_pkg.sv]
package com_pkg;

	// High clock source option codes
	localparam logic [1:0] HCLK_FAST_RC  = 2'h0;
	localparam logic [1:0] HCLK_RC_RTC   = 2'h1;
	localparam logic [1:0] HCLK_CRYSTAL  = 2'h2;

	// Operating mode codes (field written by software)
	localparam logic [1:0] MODE_NORMAL = 2'h0;
	localparam logic [1:0] MODE_SLEEP  = 2'h1;
	localparam logic [1:0] MODE_GREEN  = 2'h2;
	localparam logic [1:0] MODE_SLOW   = 2'h3;

	// Instruction clock divider in slow mode
	localparam logic [3:0] SLOW_DIV = 4'h4;

	// Data memory map
	localparam logic [11:0] GP_RAM_LO  = 12'h000;
	localparam logic [11:0] GP_RAM_HI  = 12'h07f;
	localparam logic [11:0] SYS_REG_LO = 12'h080;
	localparam logic [11:0] SYS_REG_HI = 12'h0ff;
	localparam logic [11:0] DISP_LO    = 12'hf00;
	localparam logic [11:0] DISP_HI    = 12'hf0b;
	localparam logic [11:0] IND_PTR    = 12'h0e7;
	localparam int          GP_WORDS   = 128;
	localparam int          DISP_WORDS = 12;

	// AXI4-Lite register offsets
	localparam logic [7:0] REG_OPT    = 8'h00;
	localparam logic [7:0] REG_MODE   = 8'h04;
	localparam logic [7:0] REG_STAT   = 8'h08;
	localparam logic [7:0] REG_MADDR  = 8'h0c;
	localparam logic [7:0] REG_MDATA  = 8'h10;
	localparam logic [7:0] REG_INDEX  = 8'h14;
	localparam logic [7:0] REG_DECODE = 8'h18;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Region of a data address
	typedef enum logic [3:0] {
		RGN_NONE = 4'h0,
		RGN_GP   = 4'h1,
		RGN_SYS  = 4'h2,
		RGN_DISP = 4'h4,
		RGN_IND  = 4'h8
	} com_region_t;

	// Latched option set
	typedef struct packed {
		logic [1:0] hclk_sel;
		logic       wdt_en;
		logic       secure_en;
		logic       low_rc_always_on;
		logic       low_power_en;
	} com_opts_t;

	// Derived clocking controls
	typedef struct packed {
		logic fast_rc_on;
		logic crystal_hi_on;
		logic rtc_crystal_on;
		logic low_rc_on;
		logic wdt_clk_low_rc;
		logic wdt_run;
		logic rom_protect;
		logic low_power_act;
		logic fcpu_from_slow;
		logic port_two_pins_free;
	} com_ctrl_t;

endpackage

// [verif/com_loader_tb_top.sv]
`timescale 1ns/1ns
module com_loader_tb_top
	import com_pkg::*;
;
	// Clock, reset and straps
	logic        aclk, aresetn;
	logic [5:0]  opt_strap, strap;
	// Register bus
	logic [7:0]  s_awaddr, s_araddr;
	logic [31:0] s_wdata, s_rdata;
	logic [3:0]  s_wstrb;
	logic [1:0]  s_bresp, s_rresp;
	logic        s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid;
	logic        s_bready, s_arvalid, s_arready, s_rvalid, s_rready;
	com_ctrl_t   ctrl;
	// Bookkeeping
	int          mismatches, samples_checked, seed_v;
	logic [33:0] wq[$], rq[$];
	logic [11:0] dec_a[8] = '{12'h000, 12'h07f, 12'h080, 12'h0ff,
		12'hf00, 12'hf0b, 12'hf0c, 12'h100};
	com_region_t dec_r[8] = '{RGN_GP, RGN_GP, RGN_SYS, RGN_SYS,
		RGN_DISP, RGN_DISP, RGN_NONE, RGN_NONE};

	com_loader DUT (.aclk(aclk), .aresetn(aresetn), .opt_strap(opt_strap),
		.s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready),
		.s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid),
		.s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid),
		.s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
		.s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp),
		.s_rvalid(s_rvalid), .s_rready(s_rready), .ctrl(ctrl));

	// Free-running 20 MHz clock
	initial begin
		aclk = 1'b0;
		forever #25 aclk = ~aclk;
	end

	// Verdict and end of run
	task automatic complete_run();
		if (mismatches == 0 && samples_checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// Compare one value against its expectation
	task automatic check(input logic [33:0] seen, input logic [33:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Expected clock and power controls for a strap set and mode
	function automatic com_ctrl_t exp_ctrl(input logic [5:0] s,
		input logic [1:0] m);
		com_ctrl_t c;
		c.fast_rc_on         = s[5:4] != HCLK_CRYSTAL;
		c.crystal_hi_on      = s[5:4] == HCLK_CRYSTAL;
		c.rtc_crystal_on     = s[5:4] == HCLK_RC_RTC;
		c.low_rc_on          = s[1] || m != MODE_SLEEP;
		c.wdt_clk_low_rc     = s[1] || m == MODE_SLOW;
		c.wdt_run            = s[3] && (s[1] || m == MODE_NORMAL ||
			m == MODE_SLOW);
		c.rom_protect        = s[2];
		c.low_power_act      = s[0] && m != MODE_SLOW;
		c.fcpu_from_slow     = m == MODE_SLOW;
		c.port_two_pins_free = s[5:4] == HCLK_FAST_RC;
		return c;
	endfunction

	// Write transfer; response expectation queued first
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] st, input logic [1:0] rsp);
		logic aw_done, w_done;
		aw_done = 1'b0;
		w_done = 1'b0;
		wq.push_back({rsp, 32'h0});
		@(posedge aclk);
		s_awaddr <= a;
		s_awvalid <= 1'b1;
		s_wdata <= d;
		s_wstrb <= st;
		s_wvalid <= 1'b1;
		s_bready <= 1'b1;
		while (!(aw_done && w_done)) begin
			@(posedge aclk);
			if (!aw_done && s_awready === 1'b1) begin
				aw_done = 1'b1;
				s_awvalid <= 1'b0;
			end
			if (!w_done && s_wready === 1'b1) begin
				w_done = 1'b1;
				s_wvalid <= 1'b0;
			end
		end
		do @(posedge aclk); while (s_bvalid !== 1'b1);
		s_bready <= 1'b0;
	endtask

	// Read transfer; data and response expectation queued first
	task automatic rd(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] rsp);
		rq.push_back({rsp, d});
		@(posedge aclk);
		s_araddr <= a;
		s_arvalid <= 1'b1;
		s_rready <= 1'b1;
		do @(posedge aclk); while (s_arready !== 1'b1);
		s_arvalid <= 1'b0;
		do @(posedge aclk); while (s_rvalid !== 1'b1);
		s_rready <= 1'b0;
	endtask

	// Reset with straps, then scramble straps once they are latched
	task automatic do_reset(input logic [5:0] s);
		@(posedge aclk);
		aresetn <= 1'b0;
		opt_strap <= s;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		opt_strap <= 6'($urandom);
	endtask

	// Response monitors take the oldest note off each queue
	always @(posedge aclk) begin
		if (s_bvalid === 1'b1 && s_bready === 1'b1 && wq.size() > 0) begin
			check({s_bresp, 32'h0}, wq.pop_front());
		end
		if (s_rvalid === 1'b1 && s_rready === 1'b1 && rq.size() > 0) begin
			check({s_rresp, s_rdata}, rq.pop_front());
		end
	end

	// Watchdog against a hung handshake
	initial begin
		repeat (30000) @(posedge aclk);
		mismatches++;
		complete_run();
	end

	// Main sequence
	initial begin
		logic [11:0] a;
		logic [7:0]  d, idx;
		{aresetn, s_awvalid, s_wvalid, s_bready, s_arvalid} = '0;
		{s_rready, s_awaddr, s_araddr, s_wdata, s_wstrb} = '0;
		{opt_strap, mismatches, samples_checked} = '0;
		seed_v = $urandom(45);
		// All 16 low option settings, clock option cycling i % 3, across every operating mode
		for (int i = 0; i < 16; i++) begin
			strap = {2'(i % 3), 4'(i)};
			do_reset(strap);
			rd(REG_OPT, {26'h0, strap}, RESP_OKAY);
			for (int m = 0; m < 4; m++) begin
				wr(REG_MODE, 32'(m), 4'h1, RESP_OKAY);
				rd(REG_STAT, {22'h0, exp_ctrl(strap, 2'(m))}, RESP_OKAY);
				check({24'h0, ctrl}, {24'h0, exp_ctrl(strap, 2'(m))});
			end
		end
		// Region decode at every boundary
		for (int k = 0; k < 8; k++) begin
			wr(REG_MADDR, {20'h0, dec_a[k]}, 4'h3, RESP_OKAY);
			rd(REG_DECODE, {16'h0, dec_a[k], dec_r[k]}, RESP_OKAY);
		end
		// Store and read back in general and display RAM
		for (int k = 0; k < 6; k++) begin
			a = (k < 3) ? 12'($urandom_range(0, 127)) :
				12'(DISP_LO + $urandom_range(0, 11));
			d = 8'($urandom);
			wr(REG_MADDR, {20'h0, a}, 4'h3, RESP_OKAY);
			wr(REG_MDATA, {24'h0, d}, 4'h1, RESP_OKAY);
			rd(REG_MDATA, {24'h0, d}, RESP_OKAY);
		end
		// Indirect pointer: only the low nibble of the high index counts
		idx = 8'($urandom_range(0, 127));
		d = 8'($urandom);
		wr(REG_INDEX, {16'h0, 8'hf0, idx}, 4'h3, RESP_OKAY);
		wr(REG_MADDR, {20'h0, IND_PTR}, 4'h3, RESP_OKAY);
		rd(REG_DECODE, {16'h0, 4'h0, idx, 4'(RGN_GP)}, RESP_OKAY);
		wr(REG_MDATA, {24'h0, d}, 4'h1, RESP_OKAY);
		wr(REG_MADDR, {24'h0, idx}, 4'h3, RESP_OKAY);
		rd(REG_MDATA, {24'h0, d}, RESP_OKAY);
		// Refused accesses leave latched options intact
		rd(8'h1c, 32'h0, RESP_SLVERR);
		wr(8'h20, 32'h0, 4'hf, RESP_SLVERR);
		wr(REG_OPT, 32'h3f, 4'hf, RESP_SLVERR);
		wr(REG_STAT, 32'h0, 4'hf, RESP_SLVERR);
		rd(REG_OPT, {26'h0, strap}, RESP_OKAY);
		repeat (2) @(posedge aclk);
		complete_run();
	end
endmodule
